// [design/socr_params.svh]
// Purpose: offsets, field positions, reset values for the output control bank
// Assumes: byte-wide registers indexed over the two-wire management bus
// Notes:   the index doubles as the register address
//
// What this block does
// - override bit selects software mode over strap
// - software mode uses readback mode encoding
// - readback bits keep the latched strap value
// - gate bits default one; zero forces low
// - gate bit positions in bytes one, two
// - byte five revision/maker, byte six part
// - byte seven bits seven to five reserved, read zero
// - low five bits set readback length
// - indexed block write, each byte acknowledged
`ifndef SOCR_PARAMS_SVH
`define SOCR_PARAMS_SVH

// ==========================================================================
// register indices
`define SOCR_IDX_MODE    8'h00
`define SOCR_IDX_GATE_LO 8'h01
`define SOCR_IDX_GATE_HI 8'h02
`define SOCR_IDX_SPARE_A 8'h03
`define SOCR_IDX_SPARE_B 8'h04
`define SOCR_IDX_MAKER   8'h05
`define SOCR_IDX_PART    8'h06
`define SOCR_IDX_LEN     8'h07
`define SOCR_IDX_LAST    8'h08

// ==========================================================================
// field positions
`define SOCR_MODE_RB_HI  7
`define SOCR_MODE_RB_LO  6
`define SOCR_MODE_SW_EN  3
`define SOCR_MODE_SW_HI  2
`define SOCR_MODE_SW_LO  1
`define SOCR_G3_BIT      6
`define SOCR_G2_BIT      5
`define SOCR_G1_BIT      2
`define SOCR_G0_BIT      1
`define SOCR_G5_BIT      2
`define SOCR_G4_BIT      1

// ==========================================================================
// reset values and fixed reserved patterns
`define SOCR_RST_GATE    6'h3f
`define SOCR_RST_SWMODE  2'h3
`define SOCR_RST_LEN     5'h08
`define SOCR_FIX_MODE    8'h01
`define SOCR_FIX_GATE_LO 8'h99
`define SOCR_FIX_GATE_HI 8'h09
`define SOCR_STRAP_WAIT  2'h3

`endif

// [design/socr_pkg.sv]
// Purpose: types shared by the output control bank
// Assumes: nothing beyond the params header
// Notes:   whole module state lives in one packed struct
`default_nettype none

package socr_pkg;

  // ========================================================================
  // bus engine states, gray along idle-rx-ack-tx-ack
  typedef enum logic [2:0] {
    SOCR_IDLE   = 3'h0,
    SOCR_RX     = 3'h1,
    SOCR_ACK_RX = 3'h3,
    SOCR_TX     = 3'h2,
    SOCR_ACK_TX = 3'h6
  } socr_st_e;

  typedef struct packed {
    logic [1:0] pll_mode;
    logic [5:0] out_run;
  } socr_ctrl_s;

  typedef struct packed {
    logic [2:0]      scl_s;
    logic [2:0]      sda_s;
    logic [2:0][5:0] oen_s;
    logic [2:0][1:0] strap_s;
    logic            scl_q;
    logic            sda_q;
    logic [5:0]      oen_q;
    logic [1:0]      strap_wait;
    logic            strap_done;
    logic [1:0]      strap_q;
    socr_st_e        st;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic [1:0]      phase;
    logic            rw;
    logic            nack;
    logic [7:0]      idx;
    logic [7:0]      remain;
    logic            sda_oe;
    logic            sw_override;
    logic [1:0]      sw_mode;
    logic [5:0]      gate;
    logic [4:0]      rd_len;
    socr_ctrl_s      ctrl;
  } socr_state_s;

endpackage : socr_pkg

`default_nettype wire

// [design/socr_top.sv]
// Purpose: management-bus register bank gating six outputs and the loop mode
// Assumes: bus pins, enable pins and strap are asynchronous to core_clk
// Notes:   open-drain data pin; the bank only ever pulls it low
`include "socr_params.svh"
`default_nettype none

module socr_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h6a,  // arbitrary value
  parameter logic [3:0] REV_CODE   = 4'h5,   // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h3,   // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h42   // arbitrary value
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  // management bus
  input  wire logic          smb_clk_in,
  input  wire logic          smb_dat_in,
  output logic               smb_dat_out,
  output logic               smb_dat_oe,
  // board pins
  input  wire logic [1:0]    strap_in,
  input  wire logic [5:0]    oe_pin_n,
  // controls to the clock path
  output socr_pkg::socr_ctrl_s ctrl
);
  import socr_pkg::*;

  socr_state_s q;
  socr_state_s d;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        wr_evt;

  // ========================================================================
  // register read decode
  function automatic logic [7:0] rd_byte(input logic [7:0] i, input socr_state_s s);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      `SOCR_IDX_MODE: begin
        b = `SOCR_FIX_MODE;
        b[`SOCR_MODE_RB_HI:`SOCR_MODE_RB_LO] = s.strap_q;
        b[`SOCR_MODE_SW_EN] = s.sw_override;
        b[`SOCR_MODE_SW_HI:`SOCR_MODE_SW_LO] = s.sw_mode;
      end
      `SOCR_IDX_GATE_LO: begin
        b = `SOCR_FIX_GATE_LO;
        b[`SOCR_G3_BIT] = s.gate[3];
        b[`SOCR_G2_BIT] = s.gate[2];
        b[`SOCR_G1_BIT] = s.gate[1];
        b[`SOCR_G0_BIT] = s.gate[0];
      end
      `SOCR_IDX_GATE_HI: begin
        b = `SOCR_FIX_GATE_HI;
        b[`SOCR_G5_BIT] = s.gate[5];
        b[`SOCR_G4_BIT] = s.gate[4];
      end
      `SOCR_IDX_MAKER: b = {REV_CODE, MAKER_CODE};
      `SOCR_IDX_PART:  b = PART_CODE;
      `SOCR_IDX_LEN:   b = {3'h0, s.rd_len};
      default:         b = 8'h00;
    endcase
    return b;
  endfunction : rd_byte

  // ========================================================================
  // next state
  always_comb begin
    logic [7:0] tb;
    d      = q;
    tb     = 8'h00;
    wr_evt = 1'b0;
    d.scl_s   = {q.scl_s[1:0], smb_clk_in};
    d.sda_s   = {q.sda_s[1:0], smb_dat_in};
    d.oen_s   = {q.oen_s[1:0], oe_pin_n};
    d.strap_s = {q.strap_s[1:0], strap_in};
    // a level counts once the second and third stage agree
    if (q.scl_s[1] == q.scl_s[2]) d.scl_q = q.scl_s[2];
    if (q.sda_s[1] == q.sda_s[2]) d.sda_q = q.sda_s[2];
    if (q.oen_s[1] == q.oen_s[2]) d.oen_q = q.oen_s[2];
    rise  = d.scl_q & ~q.scl_q;
    fall  = ~d.scl_q & q.scl_q;
    start = q.scl_q & d.scl_q & q.sda_q & ~d.sda_q;
    stop  = q.scl_q & d.scl_q & ~q.sda_q & d.sda_q;
    // strap is caught once, after the synchroniser has filled
    if (q.strap_wait != `SOCR_STRAP_WAIT) begin
      d.strap_wait = q.strap_wait + 2'h1;
    end else if (!q.strap_done && q.strap_s[1] == q.strap_s[2]) begin
      d.strap_q    = q.strap_s[2];
      d.strap_done = 1'b1;
    end
    if (stop) begin
      d.st     = SOCR_IDLE;
      d.sda_oe = 1'b0;
    end else if (start) begin
      d.st     = SOCR_RX;
      d.phase  = 2'h0;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        SOCR_RX: begin
          if (rise) begin
            d.shreg  = {q.shreg[6:0], q.sda_q};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (fall && q.bitcnt == 4'h8) begin
            d.st     = SOCR_ACK_RX;
            d.sda_oe = 1'b1;
            if (q.phase != 2'h3) d.phase = q.phase + 2'h1;
            case (q.phase)
              2'h0: begin
                d.rw = q.shreg[0];
                if (q.shreg[7:1] != SLAVE_ADDR) begin
                  d.st     = SOCR_IDLE;
                  d.sda_oe = 1'b0;
                end
              end
              2'h1: d.idx = q.shreg;
              2'h2: d.remain = q.shreg;
              default: begin
                // bytes past the announced count are acked but dropped
                if (q.remain != 8'h00) begin
                  wr_evt   = 1'b1;
                  d.idx    = q.idx + 8'h01;
                  d.remain = q.remain - 8'h01;
                  case (q.idx)
                    `SOCR_IDX_MODE: begin
                      d.sw_override = q.shreg[`SOCR_MODE_SW_EN];
                      d.sw_mode = q.shreg[`SOCR_MODE_SW_HI:`SOCR_MODE_SW_LO];
                    end
                    `SOCR_IDX_GATE_LO: begin
                      d.gate[3] = q.shreg[`SOCR_G3_BIT];
                      d.gate[2] = q.shreg[`SOCR_G2_BIT];
                      d.gate[1] = q.shreg[`SOCR_G1_BIT];
                      d.gate[0] = q.shreg[`SOCR_G0_BIT];
                    end
                    `SOCR_IDX_GATE_HI: begin
                      d.gate[5] = q.shreg[`SOCR_G5_BIT];
                      d.gate[4] = q.shreg[`SOCR_G4_BIT];
                    end
                    `SOCR_IDX_LEN: d.rd_len = q.shreg[4:0];
                    default: d.rd_len = q.rd_len;
                  endcase
                end
              end
            endcase
          end
        end
        SOCR_ACK_RX: begin
          if (fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 4'h0;
            d.st     = SOCR_RX;
            if (q.phase == 2'h1 && q.rw) begin
              tb       = {3'h0, q.rd_len};  // count byte leads the read
              d.sda_oe = ~tb[7];
              d.shreg  = {tb[6:0], 1'b0};
              d.bitcnt = 4'h1;
              d.st     = SOCR_TX;
            end
          end
        end
        SOCR_TX: begin
          if (fall) begin
            if (q.bitcnt == 4'h8) begin
              d.sda_oe = 1'b0;
              d.st     = SOCR_ACK_TX;
            end else begin
              d.sda_oe = ~q.shreg[7];
              d.shreg  = {q.shreg[6:0], 1'b0};
              d.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        SOCR_ACK_TX: begin
          if (rise) begin
            d.nack = q.sda_q;
          end else if (fall) begin
            if (q.nack) begin
              d.st = SOCR_IDLE;
            end else begin
              tb       = rd_byte(q.idx, q);
              d.sda_oe = ~tb[7];
              d.shreg  = {tb[6:0], 1'b0};
              d.bitcnt = 4'h1;
              d.idx    = q.idx + 8'h01;
              d.st     = SOCR_TX;
            end
          end
        end
        default: d.st = SOCR_IDLE;
      endcase
    end
    d.ctrl.out_run  = q.gate & ~q.oen_q;
    d.ctrl.pll_mode = q.sw_override ? q.sw_mode : q.strap_q;
  end

  // ========================================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q             <= '0;
      q.scl_s       <= 3'h7;
      q.sda_s       <= 3'h7;
      q.scl_q       <= 1'b1;
      q.sda_q       <= 1'b1;
      q.oen_q       <= 6'h3f;
      q.st          <= SOCR_IDLE;
      q.sw_mode     <= `SOCR_RST_SWMODE;
      q.gate        <= `SOCR_RST_GATE;
      q.rd_len      <= `SOCR_RST_LEN;
    end else if (ce) begin
      q <= d;
    end
  end

  assign smb_dat_out = 1'b0;
  assign smb_dat_oe  = q.sda_oe;
  assign ctrl        = q.ctrl;

  // ========================================================================
  // checks
  override_mode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && q.sw_override |=> ce |-> q.ctrl.pll_mode == $past(q.sw_mode))
    else $error("software mode not applied");
  strap_mode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && !q.sw_override |=> ce |-> q.ctrl.pll_mode == $past(q.strap_q))
    else $error("strap mode not applied");
  readback_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    q.strap_done |=> $stable(q.strap_q) && (rd_byte(8'h00, q) >> 6) == {6'h0, q.strap_q})
    else $error("strap readback changed");
  gate_force_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && q.gate[0] == 1'b0 |=> ce |-> !q.ctrl.out_run[0])
    else $error("gated output still running");
  reset_defaults_a: assert property (@(posedge core_clk)
    !rstn |=> q.gate == 6'h3f && q.rd_len == 5'h08 && !q.sw_override)
    else $error("bank defaults wrong after reset");
  id_bytes_a: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_byte(8'h05, q) == {REV_CODE, MAKER_CODE} && rd_byte(8'h06, q) == PART_CODE)
    else $error("identity bytes wrong");
  len_reserved_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (rd_byte(8'h07, q) & 8'he0) == 8'h00 && (rd_byte(8'h07, q) & 8'h1f) == {3'h0, q.rd_len})
    else $error("length byte reserved bits set");
  ack_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
    q.st == SOCR_ACK_RX |-> smb_dat_oe)
    else $error("byte not acknowledged");
  stop_release_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && stop |=> !smb_dat_oe && q.st == SOCR_IDLE)
    else $error("data pin held after stop");
  write_only_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(ce && wr_evt) |=> $stable(q.gate) && $stable(q.sw_mode) && $stable(q.rd_len))
    else $error("register changed without a write");

endmodule : socr_top

`default_nettype wire

// [tb/socr_host.sv]
// Purpose: two-wire management bus host for the output control bank
// Assumes: data wire has a pull-up; the bank only ever pulls it low
// Notes:   quarter bit of Q core cycles keeps the bank's sync lag well inside
`default_nettype none

module socr_host #(
  parameter int Q = 12
) (
  // clock
  input  wire logic core_clk,
  // bus wires
  input  wire logic dev_oe,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ns;

  logic pull_q;

  initial begin
    scl    = 1'b1;
    pull_q = 1'b0;
  end

  // pull-up wins when nobody pulls
  assign sda = ~(pull_q | dev_oe);

  // ========================================================================
  // bus cycles
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // also serves as repeated start: data falls while clock is high
  task automatic start();
    pull_q <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    pull_q <= 1'b1;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask : start

  task automatic stop();
    pull_q <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    pull_q <= 1'b0;
    tick(Q);
  endtask : stop

  // data only moves while the clock is low; sampled mid high
  task automatic bit_io(input logic b, output logic s);
    pull_q <= ~b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    s = sda;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask : bit_io

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte

  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, s);
  endtask : rbyte

endmodule : socr_host

`default_nettype wire

// [tb/socr_top_bench.sv]
// Purpose: self-checking bench for the output control bank
// Assumes: bus host model socr_host; pull-up on the data wire
// Notes:   strap held at 2'b10 so override and readback can be told apart
`default_nettype none

module socr_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import socr_pkg::*;

  // arbitrary identity values handed to the bank
  localparam logic [6:0] ADDR = 7'h6a;
  localparam logic [3:0] REV  = 4'h5;
  localparam logic [3:0] MAK  = 4'h3;
  localparam logic [7:0] PART = 8'h42;

  logic       core_clk    = 1'b0;
  logic       rstn        = 1'b0;
  logic       ce          = 1'b1;
  logic       scl;
  logic       sda;
  logic       dat_out;
  logic       dat_oe;
  logic [1:0] strap_in    = 2'b10;
  logic [5:0] oe_pin_n    = 6'h00;
  socr_ctrl_s ctrl;
  int         error_cnt   = 0;
  int         checks_done = 0;
  int         cyc         = 0;
  logic [7:0] got[$];

  always #25 core_clk = ~core_clk;

  socr_top #(.SLAVE_ADDR(ADDR), .REV_CODE(REV), .MAKER_CODE(MAK), .PART_CODE(PART)) dut (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .smb_clk_in(scl), .smb_dat_in(sda),
    .smb_dat_out(dat_out), .smb_dat_oe(dat_oe), .strap_in(strap_in),
    .oe_pin_n(oe_pin_n), .ctrl(ctrl));

  socr_host host (.core_clk(core_clk), .dev_oe(dat_oe), .scl(scl), .sda(sda));

  // ========================================================================
  // shared helpers
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cmpq(input string what, input logic [7:0] exp[$], input logic [7:0] q[$]);
    foreach (exp[i]) chk(what, exp[i], q[i]);
  endtask : cmpq

  task automatic wb(input logic [7:0] b);
    logic k;
    host.wbyte(b, k);
    chk("ack", 8'h01, {7'h0, k});
  endtask : wb

  // first entry of d is the byte count
  task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
    host.start();
    wb({ADDR, 1'b0});
    wb(idx);
    foreach (d[i]) wb(d[i]);
    host.stop();
  endtask : wr

  // returns the count byte followed by n data bytes
  task automatic rd(input logic [7:0] idx, input int n, output logic [7:0] q[$]);
    logic [7:0] b;
    q = {};
    host.start();
    wb({ADDR, 1'b0});
    wb(idx);
    host.start();
    wb({ADDR, 1'b1});
    for (int i = 0; i <= n; i++) begin
      host.rbyte(b, i == n);
      q.push_back(b);
    end
    host.stop();
  endtask : rd

  // ========================================================================
  // scenarios
  task automatic t_defaults();
    rd(8'h00, 9, got);
    chk("dat out", 8'h00, {7'h0, dat_out});
    cmpq("reset bytes", '{8'h08, 8'h87, 8'hff, 8'h0f, 8'h00, 8'h00, {REV, MAK}, PART,
                          8'h08, 8'h00}, got);
    chk("strap mode", 8'h02, {6'h0, ctrl.pll_mode});
    chk("out_run", 8'h3f, {2'h0, ctrl.out_run});
  endtask : t_defaults

  task automatic t_gates();
    int         pos[6] = '{1, 2, 5, 6, 1, 2};
    logic [7:0] lo;
    logic [7:0] hi;
    for (int i = 0; i < 6; i++) begin
      lo = (i < 4) ? 8'h01 << pos[i] : 8'h00;
      hi = (i < 4) ? 8'h00 : 8'h01 << pos[i];
      wr(8'h01, '{8'h02, lo, hi});
      chk("one gate", 8'h01 << i, {2'h0, ctrl.out_run});
    end
    rd(8'h01, 2, got);
    cmpq("gate readback", '{8'h08, 8'h99, 8'h0d}, got);
    wr(8'h01, '{8'h02, 8'hff, 8'hff});
    oe_pin_n <= 6'h15;
    repeat (10) @(posedge core_clk);
    chk("pin control", 8'h2a, {2'h0, ctrl.out_run});
    oe_pin_n <= 6'h00;
  endtask : t_gates

  task automatic t_override();
    wr(8'h00, '{8'h01, 8'h0a});
    // the system warm reset falls here; the bank itself applies the mode at once
    repeat (4) @(posedge core_clk);
    chk("sw mode", 8'h01, {6'h0, ctrl.pll_mode});
    rd(8'h00, 1, got);
    cmpq("mode byte", '{8'h08, 8'h8b}, got);
    wr(8'h00, '{8'h01, 8'hff});
    rd(8'h00, 1, got);
    cmpq("mode byte ro", '{8'h08, 8'h8f}, got);
    chk("sw mode 3", 8'h03, {6'h0, ctrl.pll_mode});
    wr(8'h00, '{8'h01, 8'h06});
    chk("back to strap", 8'h02, {6'h0, ctrl.pll_mode});
  endtask : t_override

  task automatic t_ro();
    wr(8'h03, '{8'h04, 8'hff, 8'hff, 8'h00, 8'h00});
    rd(8'h03, 4, got);
    cmpq("ro bytes", '{8'h08, 8'h00, 8'h00, {REV, MAK}, PART}, got);
  endtask : t_ro

  // extra byte past the count would land in the count register if not dropped
  task automatic t_len();
    wr(8'h07, '{8'h02, 8'hff, 8'hff});
    rd(8'h07, 2, got);
    cmpq("count byte", '{8'h1f, 8'h1f, 8'h00}, got);
    wr(8'h06, '{8'h01, 8'h00, 8'h07});
    rd(8'h07, 1, got);
    cmpq("count honoured", '{8'h1f, 8'h1f}, got);
  endtask : t_len

  // with the enable low nothing moves, not even the pin synchronisers
  task automatic t_hold();
    ce       <= 1'b0;
    oe_pin_n <= 6'h3f;
    repeat (10) @(posedge core_clk);
    chk("frozen", 8'h3f, {2'h0, ctrl.out_run});
    ce <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("pins off", 8'h00, {2'h0, ctrl.out_run});
    oe_pin_n <= 6'h00;
    repeat (10) @(posedge core_clk);
  endtask : t_hold

  // a reset in mid-run must bring the length register back to its default
  task automatic t_rerun();
    rstn <= 1'b0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge core_clk);
    rd(8'h07, 1, got);
    cmpq("count default", '{8'h08, 8'h08}, got);
    chk("strap again", 8'h02, {6'h0, ctrl.pll_mode});
  endtask : t_rerun

  task automatic t_badaddr();
    logic k;
    host.start();
    host.wbyte({7'h15, 1'b0}, k);
    chk("foreign ack", 8'h00, {7'h0, k});
    host.stop();
  endtask : t_badaddr

  // ========================================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge core_clk);
    t_defaults();
    t_gates();
    t_override();
    t_ro();
    t_len();
    t_hold();
    t_rerun();
    t_badaddr();
    test_done();
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      test_done();
    end
  end

endmodule : socr_top_bench

`default_nettype wire
